// file: hdl/tm2_defines.vh
// register offsets, field positions, reset values and encodings of timer 2
`ifndef TM2_DEFINES_VH
`define TM2_DEFINES_VH
`define TM2_OFF_IRQ_FLAGS 8'h37
`define TM2_OFF_IRQ_MASK 8'h70
`define TM2_OFF_CONTROL_A 8'hb0
`define TM2_OFF_CONTROL_B 8'hb1
`define TM2_OFF_COUNT_VALUE 8'hb2
`define TM2_OFF_COMPARE_A 8'hb3
`define TM2_OFF_COMPARE_B 8'hb4
`define TM2_RESET_BYTE 8'h00
`define TM2_MAX 8'hff
`define TM2_BOTTOM 8'h00
`define TM2_ONE 8'h01
`define TM2_BIT_FORCE_A 7
`define TM2_BIT_FORCE_B 6
`define TM2_BIT_WAVE2 3
`define TM2_BIT_CB_IRQ 2
`define TM2_BIT_CA_IRQ 1
`define TM2_BIT_OVF_IRQ 0
`define TM2_FLD_OM_A 7:6
`define TM2_FLD_OM_B 5:4
`define TM2_FLD_WAVE_LOW 1:0
`define TM2_FLD_CLK_SEL 2:0
`define TM2_FLD_IRQ 2:0
`define TM2_TAP8_MSB 2
`define TM2_TAP32_MSB 4
`define TM2_TAP64_MSB 5
`define TM2_TAP128_MSB 6
`define TM2_TAP256_MSB 7
`define TM2_TAP1024_MSB 9
`define TM2_MODE_NORMAL 3'h0
`define TM2_MODE_PC_FF 3'h1
`define TM2_MODE_CTC 3'h2
`define TM2_MODE_FAST_FF 3'h3
`define TM2_MODE_RSV4 3'h4
`define TM2_MODE_PC_CA 3'h5
`define TM2_MODE_RSV6 3'h6
`define TM2_MODE_FAST_CA 3'h7
`define TM2_OM_OFF 2'h0
`define TM2_OM_TOGGLE 2'h1
`define TM2_OM_CLEAR 2'h2
`define TM2_OM_SET 2'h3
`define TM2_CS_STOP 3'h0
`define TM2_CS_DIV1 3'h1
`define TM2_CS_DIV8 3'h2
`define TM2_CS_DIV32 3'h3
`define TM2_CS_DIV64 3'h4
`define TM2_CS_DIV128 3'h5
`define TM2_CS_DIV256 3'h6
`define TM2_CS_DIV1024 3'h7
`define TM2_PRESCALE_W 10
`endif

// file: hdl/tm2_prescaler.v
// free-running prescaler that turns a clock select into a one-cycle count tick
`timescale 1ns/1ps
`include "tm2_defines.vh"
module tm2_prescaler #(
    parameter WIDTH = `TM2_PRESCALE_W
) (
    input wire clock_in,
    input wire nrst_in,
    input wire ce_in,
    input wire [2:0] clock_select_in,
    output reg tick_out
);
    reg [WIDTH-1:0] div_count;
    reg next_tick;
    wire [WIDTH-1:0] div_plus = div_count + {{(WIDTH-1){1'b0}}, 1'b1};

    // a tap ticks when all bits below it are ones, i.e. once per 2^n clocks
    always @* begin
        case (clock_select_in)
            `TM2_CS_STOP: next_tick = 1'b0;
            `TM2_CS_DIV1: next_tick = 1'b1;
            `TM2_CS_DIV8: next_tick = &div_count[`TM2_TAP8_MSB:0];
            `TM2_CS_DIV32: next_tick = &div_count[`TM2_TAP32_MSB:0];
            `TM2_CS_DIV64: next_tick = &div_count[`TM2_TAP64_MSB:0];
            `TM2_CS_DIV128: next_tick = &div_count[`TM2_TAP128_MSB:0];
            `TM2_CS_DIV256: next_tick = &div_count[`TM2_TAP256_MSB:0];
            `TM2_CS_DIV1024: next_tick = &div_count[`TM2_TAP1024_MSB:0];
            default: next_tick = 1'b0;
        endcase
    end

    // the divider runs regardless of the select, so taps stay in phase
    always @(posedge clock_in) begin
        if (!nrst_in) begin
            div_count <= {WIDTH{1'b0}};
            tick_out <= 1'b0;
        end else if (ce_in) begin
            div_count <= div_plus;
            tick_out <= next_tick;
        end
    end
endmodule

// file: hdl/tm2_timer.v
// 8-bit timer 2 with two compare channels, waveform modes and register port
`timescale 1ns/1ps
`include "tm2_defines.vh"
module tm2_timer #(
    parameter PRESCALE_W = `TM2_PRESCALE_W
) (
    input wire clock_in,
    input wire nrst_in,
    input wire ce_in,
    input wire [7:0] addr_in,
    input wire [7:0] wdata_in,
    input wire wr_in,
    input wire rd_in,
    input wire global_irq_en_in,
    input wire ack_ovf_in,
    input wire ack_compare_a_in,
    input wire ack_compare_b_in,
    output reg [7:0] rdata_out,
    output reg wave_out_a_out,
    output reg wave_out_b_out,
    output reg wave_en_a_out,
    output reg wave_en_b_out,
    output reg irq_ovf_out,
    output reg irq_compare_a_out,
    output reg irq_compare_b_out
);
    reg [1:0] out_mode_a;
    reg [1:0] out_mode_b;
    reg [1:0] wave_mode_low_bits;
    reg wave_mode_bit2;
    reg [2:0] clock_select_field;
    reg [7:0] tmr2_count_value;
    reg [7:0] tmr2_compare_a;
    reg [7:0] tmr2_compare_b;
    reg [7:0] compare_a_value;
    reg [7:0] compare_b_value;
    reg [2:0] tmr2_irq_mask;
    reg compare_a_flag;
    reg compare_b_flag;
    reg overflow_flag;
    reg count_down;
    reg block_match;
    reg wave_a;
    reg wave_b;
    wire tick;

    // the tick is registered, so a new clock select acts one cycle later
    tm2_prescaler #(
        .WIDTH(PRESCALE_W)
    ) u_prescaler (
        .clock_in(clock_in),
        .nrst_in(nrst_in),
        .ce_in(ce_in),
        .clock_select_in(clock_select_field),
        .tick_out(tick)
    );

    // mode decode
    wire [2:0] mode = {wave_mode_bit2, wave_mode_low_bits};
    wire reserved = (mode == `TM2_MODE_RSV4) || (mode == `TM2_MODE_RSV6);
    wire phase_pwm = (mode == `TM2_MODE_PC_FF) || (mode == `TM2_MODE_PC_CA);
    wire fast_pwm = (mode == `TM2_MODE_FAST_FF) || (mode == `TM2_MODE_FAST_CA);
    wire non_pwm = (mode == `TM2_MODE_NORMAL) || (mode == `TM2_MODE_CTC);
    wire top_is_a = (mode == `TM2_MODE_CTC) || (mode == `TM2_MODE_PC_CA) ||
                    (mode == `TM2_MODE_FAST_CA);
    wire [7:0] top_value = top_is_a ? compare_a_value : `TM2_MAX;

    // register port decode
    wire wr_ctl_a = wr_in && (addr_in == `TM2_OFF_CONTROL_A);
    wire wr_ctl_b = wr_in && (addr_in == `TM2_OFF_CONTROL_B);
    wire wr_cnt = wr_in && (addr_in == `TM2_OFF_COUNT_VALUE);
    wire wr_cmp_a = wr_in && (addr_in == `TM2_OFF_COMPARE_A);
    wire wr_cmp_b = wr_in && (addr_in == `TM2_OFF_COMPARE_B);
    wire wr_mask = wr_in && (addr_in == `TM2_OFF_IRQ_MASK);
    wire wr_flags = wr_in && (addr_in == `TM2_OFF_IRQ_FLAGS);

    // write data fields, named once so their positions live in the header
    wire [1:0] wd_out_mode_a = wdata_in[`TM2_FLD_OM_A];
    wire [1:0] wd_out_mode_b = wdata_in[`TM2_FLD_OM_B];
    wire [1:0] wd_wave_low = wdata_in[`TM2_FLD_WAVE_LOW];
    wire [2:0] wd_clk_sel = wdata_in[`TM2_FLD_CLK_SEL];
    wire [2:0] wd_irq_mask = wdata_in[`TM2_FLD_IRQ];

    // force strobes act only in non-pwm modes; software keeps them zero otherwise
    wire force_a = wr_ctl_b && wdata_in[`TM2_BIT_FORCE_A] && non_pwm;
    wire force_b = wr_ctl_b && wdata_in[`TM2_BIT_FORCE_B] && non_pwm;

    // compares only count on a timer tick, and not the tick right after a counter write
    wire live = ce_in && tick && !reserved;
    wire match_a = live && !block_match && (tmr2_count_value == compare_a_value);
    wire match_b = live && !block_match && (tmr2_count_value == compare_b_value);
    wire at_top = tmr2_count_value == top_value;
    wire at_bottom = tmr2_count_value == `TM2_BOTTOM;

    // next counter value and direction per mode
    reg [7:0] next_count;
    reg next_down;
    reg ovf_event;
    reg buf_update;
    always @* begin
        next_count = tmr2_count_value;
        next_down = count_down;
        ovf_event = 1'b0;
        buf_update = 1'b0;
        if (live) begin
            if (phase_pwm) begin
                // direction turns at top and bottom; overflow on the turn at bottom
                if (at_top && at_bottom) begin
                    // a top of zero leaves nowhere to turn, so hold instead of wrapping to max
                    next_count = tmr2_count_value;
                end else if (!count_down && at_top) begin
                    next_down = 1'b1;
                    next_count = tmr2_count_value - `TM2_ONE;
                    buf_update = 1'b1;
                end else if (count_down && at_bottom) begin
                    next_down = 1'b0;
                    next_count = tmr2_count_value + `TM2_ONE;
                    ovf_event = 1'b1;
                end else if (count_down) begin
                    next_count = tmr2_count_value - `TM2_ONE;
                end else begin
                    next_count = tmr2_count_value + `TM2_ONE;
                end
            end else begin
                next_down = 1'b0;
                next_count = at_top ? `TM2_BOTTOM : tmr2_count_value + `TM2_ONE;
                if (mode == `TM2_MODE_FAST_CA)
                    ovf_event = at_top;
                else
                    ovf_event = (tmr2_count_value == `TM2_MAX);
                buf_update = fast_pwm && at_top;
            end
        end
    end

    // waveform channels; pwm modes follow their own set/clear pairs
    reg next_wave_a;
    reg next_wave_b;
    always @* begin
        next_wave_a = wave_a;
        next_wave_b = wave_b;
        if (non_pwm) begin
            if (match_a || force_a) begin
                case (out_mode_a)
                    `TM2_OM_TOGGLE: next_wave_a = !wave_a;
                    `TM2_OM_CLEAR: next_wave_a = 1'b0;
                    `TM2_OM_SET: next_wave_a = 1'b1;
                    default: next_wave_a = wave_a;
                endcase
            end
            if (match_b || force_b) begin
                case (out_mode_b)
                    `TM2_OM_TOGGLE: next_wave_b = !wave_b;
                    `TM2_OM_CLEAR: next_wave_b = 1'b0;
                    `TM2_OM_SET: next_wave_b = 1'b1;
                    default: next_wave_b = wave_b;
                endcase
            end
        end else if (fast_pwm && live) begin
            // set/clear at bottom wins over a match equal to top
            if (at_top && out_mode_a[1])
                next_wave_a = !out_mode_a[0];
            else if (match_a && out_mode_a[1])
                next_wave_a = out_mode_a[0];
            else if (match_a && out_mode_a == `TM2_OM_TOGGLE && wave_mode_bit2)
                next_wave_a = !wave_a;
            if (at_top && out_mode_b[1])
                next_wave_b = !out_mode_b[0];
            else if (match_b && out_mode_b[1])
                next_wave_b = out_mode_b[0];
        end else if (phase_pwm) begin
            if (match_a && out_mode_a[1])
                next_wave_a = out_mode_a[0] ^ count_down;
            else if (match_a && out_mode_a == `TM2_OM_TOGGLE && wave_mode_bit2)
                next_wave_a = !wave_a;
            if (match_b && out_mode_b[1])
                next_wave_b = out_mode_b[0] ^ count_down;
        end
    end

    // control and mask registers
    always @(posedge clock_in) begin
        if (!nrst_in) begin
            out_mode_a <= `TM2_OM_OFF;
            out_mode_b <= `TM2_OM_OFF;
            wave_mode_low_bits <= 2'h0;
            wave_mode_bit2 <= 1'b0;
            clock_select_field <= `TM2_CS_STOP;
            tmr2_irq_mask <= 3'h0;
        end else if (ce_in) begin
            if (wr_ctl_a) begin
                out_mode_a <= wd_out_mode_a;
                out_mode_b <= wd_out_mode_b;
                wave_mode_low_bits <= wd_wave_low;
            end
            // force bits are strobes and are never stored
            if (wr_ctl_b) begin
                wave_mode_bit2 <= wdata_in[`TM2_BIT_WAVE2];
                clock_select_field <= wd_clk_sel;
            end
            if (wr_mask)
                tmr2_irq_mask <= wd_irq_mask;
        end
    end

    // compare registers and their buffers; software reads back the written value
    always @(posedge clock_in) begin
        if (!nrst_in) begin
            tmr2_compare_a <= `TM2_RESET_BYTE;
            tmr2_compare_b <= `TM2_RESET_BYTE;
            compare_a_value <= `TM2_RESET_BYTE;
            compare_b_value <= `TM2_RESET_BYTE;
        end else if (ce_in) begin
            if (wr_cmp_a)
                tmr2_compare_a <= wdata_in;
            if (wr_cmp_b)
                tmr2_compare_b <= wdata_in;
            // double buffer is transparent outside pwm, so a write there acts at once
            if (!(phase_pwm || fast_pwm) || buf_update) begin
                compare_a_value <= wr_cmp_a ? wdata_in : tmr2_compare_a;
                compare_b_value <= wr_cmp_b ? wdata_in : tmr2_compare_b;
            end
        end
    end

    // counter, direction, match blocker and waveform levels
    always @(posedge clock_in) begin
        if (!nrst_in) begin
            tmr2_count_value <= `TM2_RESET_BYTE;
            count_down <= 1'b0;
            block_match <= 1'b0;
            wave_a <= 1'b0;
            wave_b <= 1'b0;
        end else if (ce_in) begin
            // a software write beats the tick and arms the match blocker
            if (wr_cnt) begin
                tmr2_count_value <= wdata_in;
                block_match <= 1'b1;
            end else begin
                tmr2_count_value <= next_count;
                if (live)
                    block_match <= 1'b0;
            end
            // direction and levels follow the per-mode next values
            count_down <= next_down;
            wave_a <= next_wave_a;
            wave_b <= next_wave_b;
        end
    end

    // flags: hardware set wins over any clear in the same cycle; force never sets
    always @(posedge clock_in) begin
        if (!nrst_in) begin
            compare_a_flag <= 1'b0;
            compare_b_flag <= 1'b0;
            overflow_flag <= 1'b0;
        end else if (ce_in) begin
            // channel a: a real match sets, a taken vector or a written one clears
            if (match_a)
                compare_a_flag <= 1'b1;
            else if (ack_compare_a_in || (wr_flags && wdata_in[`TM2_BIT_CA_IRQ]))
                compare_a_flag <= 1'b0;
            // channel b: same scheme as channel a
            if (match_b)
                compare_b_flag <= 1'b1;
            else if (ack_compare_b_in || (wr_flags && wdata_in[`TM2_BIT_CB_IRQ]))
                compare_b_flag <= 1'b0;
            // overflow: the event point depends on the mode
            if (ovf_event)
                overflow_flag <= 1'b1;
            else if (ack_ovf_in || (wr_flags && wdata_in[`TM2_BIT_OVF_IRQ]))
                overflow_flag <= 1'b0;
        end
    end

    // read mux; force bits always read zero
    // reads outside the strobe return zero so stale data never looks fresh
    reg [7:0] next_rdata;
    always @* begin
        next_rdata = 8'h00;
        case (addr_in)
            `TM2_OFF_CONTROL_A: next_rdata = {out_mode_a, out_mode_b, 2'h0, wave_mode_low_bits};
            `TM2_OFF_CONTROL_B: next_rdata = {4'h0, wave_mode_bit2, clock_select_field};
            `TM2_OFF_COUNT_VALUE: next_rdata = tmr2_count_value;
            `TM2_OFF_COMPARE_A: next_rdata = tmr2_compare_a;
            `TM2_OFF_COMPARE_B: next_rdata = tmr2_compare_b;
            `TM2_OFF_IRQ_MASK: next_rdata = {5'h00, tmr2_irq_mask};
            `TM2_OFF_IRQ_FLAGS: next_rdata = {5'h00, compare_b_flag, compare_a_flag, overflow_flag};
            default: next_rdata = 8'h00;
        endcase
    end

    // interrupt requests and pin enables ahead of the output registers
    // a masked flag stays pending and raises its line as soon as it is unmasked
    wire req_ovf = overflow_flag && tmr2_irq_mask[`TM2_BIT_OVF_IRQ] && global_irq_en_in;
    wire req_compare_a = compare_a_flag && tmr2_irq_mask[`TM2_BIT_CA_IRQ] && global_irq_en_in;
    wire req_compare_b = compare_b_flag && tmr2_irq_mask[`TM2_BIT_CB_IRQ] && global_irq_en_in;
    wire pin_en_a = out_mode_a != `TM2_OM_OFF;
    wire pin_en_b = out_mode_b != `TM2_OM_OFF;

    // registered outputs; interrupt lines are one cycle behind their flags
    always @(posedge clock_in) begin
        if (!nrst_in) begin
            rdata_out <= 8'h00;
            wave_out_a_out <= 1'b0;
            wave_out_b_out <= 1'b0;
            wave_en_a_out <= 1'b0;
            wave_en_b_out <= 1'b0;
            irq_ovf_out <= 1'b0;
            irq_compare_a_out <= 1'b0;
            irq_compare_b_out <= 1'b0;
        end else if (ce_in) begin
            rdata_out <= rd_in ? next_rdata : 8'h00;
            wave_out_a_out <= wave_a;
            wave_out_b_out <= wave_b;
            wave_en_a_out <= pin_en_a;
            wave_en_b_out <= pin_en_b;
            irq_ovf_out <= req_ovf;
            irq_compare_a_out <= req_compare_a;
            irq_compare_b_out <= req_compare_b;
        end
    end
endmodule

// file: bench/tm2_timer_properties.sv
// checker module and bind for the timer 2 register port, interrupt and pin outputs
`timescale 1ns/1ps
module tm2_timer_checker #(
    parameter PRESCALE_W = 10
) (
    input wire clock_in,
    input wire nrst_in,
    input wire ce_in,
    input wire [7:0] addr_in,
    input wire [7:0] wdata_in,
    input wire wr_in,
    input wire rd_in,
    input wire global_irq_en_in,
    input wire ack_ovf_in,
    input wire ack_compare_a_in,
    input wire ack_compare_b_in,
    input wire [7:0] rdata_out,
    input wire wave_out_a_out,
    input wire wave_out_b_out,
    input wire wave_en_a_out,
    input wire wave_en_b_out,
    input wire irq_ovf_out,
    input wire irq_compare_a_out,
    input wire irq_compare_b_out
);
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!nrst_in);
    // writes to the mask and to control A, qualified by the clock enable
    wire mask_wr = wr_in && ce_in && addr_in == 8'h70;
    wire cta_wr = wr_in && ce_in && addr_in == 8'hb0;
    a_read_idle_zero: assert property (!rd_in |=> rdata_out == 8'h00)
        else $error("read data outside its slot");
    a_unmapped_read_zero: assert property (rd_in && !(addr_in inside {8'h37, 8'h70, [8'hb0:8'hb4]}) |=> rdata_out == 8'h00)
        else $error("unmapped read not zero");
    a_force_reads_zero: assert property (rd_in && addr_in == 8'hb1 |=> rdata_out[7:6] == 2'h0)
        else $error("force bits read back set");
    a_gie_gates_irq: assert property (!global_irq_en_in |=> !(irq_ovf_out || irq_compare_a_out || irq_compare_b_out))
        else $error("interrupt with global enable low");
    a_mask_b_gate: assert property (mask_wr && !wdata_in[2] |=> ##1 !irq_compare_b_out)
        else $error("compare b interrupt while masked");
    a_mask_a_gate: assert property (mask_wr && !wdata_in[1] |=> ##1 !irq_compare_a_out)
        else $error("compare a interrupt while masked");
    a_mask_ovf_gate: assert property (mask_wr && !wdata_in[0] |=> ##1 !irq_ovf_out)
        else $error("overflow interrupt while masked");
    // the enable follows the out mode field once the write has landed
    a_wave_en_a: assert property (cta_wr ##1 !cta_wr |=> wave_en_a_out == ($past(wdata_in[7:6], 2) != 2'h0))
        else $error("pin enable a does not follow out mode");
    a_wave_en_b: assert property (cta_wr ##1 !cta_wr |=> wave_en_b_out == ($past(wdata_in[5:4], 2) != 2'h0))
        else $error("pin enable b does not follow out mode");
    c_irq_a: cover property ($rose(irq_compare_a_out));
    c_irq_ovf: cover property ($rose(irq_ovf_out));
    c_wave_a: cover property ($changed(wave_out_a_out));
endmodule
bind tm2_timer tm2_timer_checker #(.PRESCALE_W(PRESCALE_W)) u_chk (.clock_in(clock_in), .nrst_in(nrst_in),
    .ce_in(ce_in), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .global_irq_en_in(global_irq_en_in), .ack_ovf_in(ack_ovf_in), .ack_compare_a_in(ack_compare_a_in),
    .ack_compare_b_in(ack_compare_b_in), .rdata_out(rdata_out), .wave_out_a_out(wave_out_a_out),
    .wave_out_b_out(wave_out_b_out), .wave_en_a_out(wave_en_a_out), .wave_en_b_out(wave_en_b_out),
    .irq_ovf_out(irq_ovf_out), .irq_compare_a_out(irq_compare_a_out), .irq_compare_b_out(irq_compare_b_out));

// file: bench/tm2_tb.sv
// self-checking bench for timer 2: registers, forcing, compares, modes, clock select
`timescale 1ns/1ps
`include "tm2_defines.vh"
module tb;
    typedef struct {logic [7:0] lo; logic [7:0] hi; string name;} tm2_note_t;
    logic clock_in = 0, nrst_in = 0, wr_in = 0, rd_in = 0, gie = 0, ack_a = 0, ack_b = 0, ack_o = 0, ce = 1;
    logic rd_seen = 0, lvl;
    logic [7:0] addr_in = 0, wdata_in = 0, v;
    wire [7:0] rdata_out;
    wire wave_a, wave_b, en_a, en_b, irq_o, irq_a, irq_b;
    tm2_note_t notes[$];
    tm2_note_t note;
    int errors = 0, samples_checked = 0, cycles = 0, seed = 32'he418;
    int divs[8] = '{1, 1, 8, 32, 64, 128, 256, 1024};
    logic [2:0] topm[3] = '{3'h2, 3'h5, 3'h7};
    logic [7:0] topf[3] = '{8'h02, 8'h03, 8'h03};
    logic [7:0] regs[9] = '{8'h37, 8'h70, 8'hb0, 8'hb1, 8'hb2, 8'hb3, 8'hb4, 8'h55, 8'hb5};
    tm2_timer dut (.clock_in(clock_in), .nrst_in(nrst_in), .ce_in(ce), .addr_in(addr_in), .wdata_in(wdata_in),
        .wr_in(wr_in), .rd_in(rd_in), .global_irq_en_in(gie), .ack_ovf_in(ack_o), .ack_compare_a_in(ack_a),
        .ack_compare_b_in(ack_b), .rdata_out(rdata_out), .wave_out_a_out(wave_a), .wave_out_b_out(wave_b),
        .wave_en_a_out(en_a), .wave_en_b_out(en_b), .irq_ovf_out(irq_o), .irq_compare_a_out(irq_a),
        .irq_compare_b_out(irq_b));
    initial begin
        forever #20 clock_in = ~clock_in;
    end
    // one compare for every kind of result; an exact value is a range of one
    task automatic cv(input string n, input [7:0] lo, input [7:0] hi, input [7:0] got);
        samples_checked++;
        if (((got >= lo) && (got <= hi)) !== 1'b1) begin
            errors++;
            $display("MISMATCH %s expected %h..%h seen %h", n, lo, hi, got);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clock_in);
    endtask
    // the gap edge after each strobe keeps a driver from assigning twice at one edge
    task automatic wr(input [7:0] a, input [7:0] d);
        @(posedge clock_in);
        wr_in <= 1'b1;
        addr_in <= a;
        wdata_in <= d;
        @(posedge clock_in);
        wr_in <= 1'b0;
    endtask
    task automatic rd(input [7:0] a, input [7:0] lo, input [7:0] hi, input string n);
        notes.push_back('{lo, hi, n});
        @(posedge clock_in);
        rd_in <= 1'b1;
        addr_in <= a;
        @(posedge clock_in);
        rd_in <= 1'b0;
    endtask
    // read data stand only in the cycle after the strobe, so take them then
    always @(posedge clock_in) begin
        if (rd_seen) begin
            note = notes.pop_front();
            cv(note.name, note.lo, note.hi, rdata_out);
        end
        rd_seen <= rd_in;
    end
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // a hang is cut short well above the roughly 13000 cycles the run needs
    always @(posedge clock_in) begin
        cycles++;
        if (cycles == 40000) begin
            errors++;
            tally_and_finish();
        end
    end
    initial begin
        tick(12);
        nrst_in <= 1'b1;
        foreach (regs[i]) rd(regs[i], 8'h00, 8'h00, "reset or unmapped");
        for (int i = 2; i < 5; i++) begin
            v = 8'($random(seed));
            wr(8'(8'hb0 + i), v);
            rd(8'(8'hb0 + i), v, v, "readback");
        end
        wr(8'hb1, 8'hc8);
        rd(8'hb1, 8'h08, 8'h08, "control b");
        wr(8'hb1, 8'h00);
        $display("test registers done");
        lvl = 1'b0;
        // toggle, clear, set in turn, so each mode moves the level
        for (int m = 1; m < 4; m++) begin
            wr(8'hb0, {m[1:0], m[1:0], 4'h0});
            wr(8'hb1, 8'hc0);
            lvl = (m == 1) ? ~lvl : m[0];
            tick(3);
            cv("wave a", {7'h0, lvl}, {7'h0, lvl}, {7'h0, wave_a});
            cv("wave b", {7'h0, lvl}, {7'h0, lvl}, {7'h0, wave_b});
            cv("enable a", 8'h01, 8'h01, {7'h0, en_a});
            cv("enable b", 8'h01, 8'h01, {7'h0, en_b});
        end
        rd(8'h37, 8'h00, 8'h00, "flags after force");
        wr(8'hb0, 8'ha3);
        // software keeps both force bits zero while a pwm mode is selected
        wr(8'hb1, 8'h00);
        tick(3);
        cv("wave a in pwm", 8'h01, 8'h01, {7'h0, wave_a});
        wr(8'hb0, 8'h00);
        wr(8'hb1, 8'h00);
        $display("test force done");
        wr(8'hb3, 8'h20);
        wr(8'hb4, 8'h40);
        wr(8'hb2, 8'h10);
        wr(8'h37, 8'h07);
        wr(8'h70, 8'h03);
        gie <= 1'b1;
        wr(8'hb1, 8'h01);
        repeat (64) if (irq_a !== 1'b1) @(posedge clock_in);
        cv("irq a", 8'h01, 8'h01, {7'h0, irq_a});
        repeat (300) if (irq_o !== 1'b1) @(posedge clock_in);
        cv("irq ovf", 8'h01, 8'h01, {7'h0, irq_o});
        wr(8'hb1, 8'h00);
        rd(8'h37, 8'h07, 8'h07, "flags");
        wr(8'h70, 8'h04);
        tick(3);
        cv("irq b", 8'h01, 8'h01, {7'h0, irq_b});
        gie <= 1'b0;
        tick(3);
        cv("irq b gated", 8'h00, 8'h00, {7'h0, irq_b});
        gie <= 1'b1;
        ack_o <= 1'b1;
        ack_b <= 1'b1;
        @(posedge clock_in);
        ack_o <= 1'b0;
        ack_b <= 1'b0;
        rd(8'h37, 8'h02, 8'h02, "flags after ack");
        wr(8'h37, 8'h02);
        rd(8'h37, 8'h00, 8'h00, "flags after clear");
        $display("test interrupts done");
        wr(8'hb3, 8'h30);
        for (int k = 0; k < 2; k++) begin
            wr(8'hb2, 8'(8'h30 - k));
            wr(8'h37, 8'h07);
            wr(8'hb1, 8'h01);
            tick(4);
            wr(8'hb1, 8'h00);
            rd(8'h37, {6'h0, k[0], 1'b0}, {6'h0, k[0], 1'b0}, "match after count write");
        end
        ack_a <= 1'b1;
        @(posedge clock_in);
        ack_a <= 1'b0;
        rd(8'h37, 8'h00, 8'h00, "flag a after ack");
        $display("test blocked match done");
        wr(8'hb3, 8'h08);
        foreach (topm[j]) begin
            wr(8'hb2, 8'h00);
            wr(8'hb0, {6'h0, topm[j][1:0]});
            wr(8'h37, 8'h07);
            wr(8'hb1, {4'h0, topm[j][2], 3'h1});
            repeat (12) rd(8'hb2, 8'h00, 8'h08, "count under top");
            wr(8'hb1, 8'h00);
            rd(8'h37, topf[j], topf[j], "flags per mode");
        end
        for (int j = 0; j < 2; j++) begin
            wr(8'hb2, 8'h33);
            wr(8'hb0, {6'h0, j[0], 1'b0});
            wr(8'hb1, 8'h09);
            tick(10);
            rd(8'hb2, 8'h33, 8'h33, "count held");
            wr(8'hb1, 8'h00);
        end
        $display("test modes done");
        wr(8'hb0, 8'h00);
        for (int c = 0; c < 8; c++) begin
            wr(8'hb2, 8'h00);
            wr(8'hb1, c[7:0]);
            tick(8 * divs[c]);
            wr(8'hb1, 8'h00);
            rd(8'hb2, (c == 0) ? 8'h00 : 8'h06, (c == 0) ? 8'h00 : 8'h0b, "ticks per select");
        end
        // a low clock enable must freeze the running count and its prescaler
        wr(8'hb2, 8'h40);
        wr(8'hb1, 8'h01);
        ce <= 1'b0;
        tick(20);
        ce <= 1'b1;
        rd(8'hb2, 8'h40, 8'h40, "count frozen by enable");
        wr(8'hb1, 8'h00);
        tick(2);
        $display("test clock select done");
        tally_and_finish();
    end
endmodule
